// file: verilog/vfr_pkg.sv
// Shared constants, operation codes and reciprocal table for the vector FP unit.
`default_nettype none
package vfr_pkg;

  // ----------------------------------------------------------------------------
  // Element format
  // ----------------------------------------------------------------------------
  localparam int unsigned    VFR_ELEM_W   = 32;
  localparam int unsigned    VFR_FRAC_W   = 23;
  localparam int unsigned    VFR_EXP_W    = 8;
  localparam int unsigned    VFR_LUT_W    = 7;
  localparam int             VFR_EXP_BIAS = 127;
  localparam logic [7:0]     VFR_EXP_MAX  = 8'hFF;
  localparam logic [31:0]    VFR_CANON_NAN = 32'h7FC0_0000;
  localparam logic [30:0]    VFR_INF_MAG   = 31'h7F80_0000;
  localparam logic [30:0]    VFR_MAXF_MAG  = 31'h7F7F_FFFF;
  localparam int unsigned    VFR_LATENCY   = 1;

  // ----------------------------------------------------------------------------
  // Rounding mode encodings
  // ----------------------------------------------------------------------------
  localparam logic [2:0] round_nearest_even          = 3'h0;
  localparam logic [2:0] round_toward_zero           = 3'h1;
  localparam logic [2:0] round_toward_minus_inf      = 3'h2;
  localparam logic [2:0] round_toward_plus_inf       = 3'h3;
  localparam logic [2:0] round_nearest_max_magnitude = 3'h4;

  // ----------------------------------------------------------------------------
  // Operation select, one-hot
  // ----------------------------------------------------------------------------
  typedef enum logic [11:0] {
    VFR_OP_RECIP  = 12'h001,
    VFR_OP_MIN    = 12'h002,
    VFR_OP_MAX    = 12'h004,
    VFR_OP_SGNJ   = 12'h008,
    VFR_OP_SGNJN  = 12'h010,
    VFR_OP_SGNJX  = 12'h020,
    VFR_OP_CMP_EQ = 12'h040,
    VFR_OP_CMP_NE = 12'h080,
    VFR_OP_CMP_LT = 12'h100,
    VFR_OP_CMP_LE = 12'h200,
    VFR_OP_CMP_GT = 12'h400,
    VFR_OP_CMP_GE = 12'h800
  } vfr_op_e;

  // ----------------------------------------------------------------------------
  // Reciprocal estimate table, indexed by the top seven normalised fraction bits
  // ----------------------------------------------------------------------------
  localparam logic [6:0] VFR_RECIP_LUT [0:127] = '{
    7'h7F, 7'h7D, 7'h7B, 7'h79, 7'h77, 7'h75, 7'h74, 7'h72,
    7'h70, 7'h6E, 7'h6D, 7'h6B, 7'h69, 7'h68, 7'h66, 7'h64,
    7'h63, 7'h61, 7'h60, 7'h5E, 7'h5D, 7'h5B, 7'h5A, 7'h58,
    7'h57, 7'h55, 7'h54, 7'h53, 7'h51, 7'h50, 7'h4F, 7'h4D,
    7'h4C, 7'h4B, 7'h4A, 7'h48, 7'h47, 7'h46, 7'h45, 7'h44,
    7'h42, 7'h41, 7'h40, 7'h3F, 7'h3E, 7'h3D, 7'h3C, 7'h3B,
    7'h3A, 7'h39, 7'h38, 7'h37, 7'h36, 7'h35, 7'h34, 7'h33,
    7'h32, 7'h31, 7'h30, 7'h2F, 7'h2E, 7'h2D, 7'h2C, 7'h2B,
    7'h2A, 7'h29, 7'h28, 7'h28, 7'h27, 7'h26, 7'h25, 7'h24,
    7'h23, 7'h23, 7'h22, 7'h21, 7'h20, 7'h1F, 7'h1F, 7'h1E,
    7'h1D, 7'h1C, 7'h1C, 7'h1B, 7'h1A, 7'h19, 7'h19, 7'h18,
    7'h17, 7'h17, 7'h16, 7'h15, 7'h15, 7'h14, 7'h13, 7'h13,
    7'h12, 7'h11, 7'h11, 7'h10, 7'h0F, 7'h0F, 7'h0E, 7'h0E,
    7'h0D, 7'h0C, 7'h0C, 7'h0B, 7'h0B, 7'h0A, 7'h09, 7'h09,
    7'h08, 7'h08, 7'h07, 7'h07, 7'h06, 7'h05, 7'h05, 7'h04,
    7'h04, 7'h03, 7'h03, 7'h02, 7'h02, 7'h01, 7'h01, 7'h00
  };

endpackage
`default_nettype wire

// file: verilog/vfr_unit.sv
// Per-element FP datapath: reciprocal estimate, min/max, sign injection, compares.
//
// Contract
// (RQ1) Overflowing reciprocal result depends on the live dynamic rounding mode.
// (RQ2) Lookup indexed by top seven fraction bits; result top seven bits, rest zero.
// (RQ3) Normalised input exponent: encoded exponent, or minus leading-zero count.
// (RQ4) Normalised output exponent is twice bias minus one minus input exponent.
// (RQ5) Output exponent below minus one or above twice bias takes exceptional path.
// (RQ6) Subnormal fraction shifted left by one minus exponent, leading one dropped.
// (RQ7) Fixed 128-entry seven-bit table matches the published values exactly.
// (RQ8) Table index 127 returns zero.
// (RQ9) Output exponent 0 or -1: exponent field zero, fraction denormalised.
// (RQ10) Other in-range cases emit output exponent and fraction unchanged.
// (RQ11) Reciprocal result sign equals the input sign.
// (RQ12) Subnormal inputs of at least two^-(bias+1) give normal results.
// (RQ13) Normal inputs of at least two^(bias-1) give subnormal results.
// (RQ14) Tiny subnormals raise inexact and overflow; max finite or infinity by mode.
// (RQ15) Zero to infinity with divide-by-zero, infinity to zero, NaN to canonical.
// (RQ16) Min and max follow minimumNumber and maximumNumber, vector or scalar form.
// (RQ17) Sign injection copies all non-sign bits of the second vector source.
// (RQ18) Result sign: other sign, its inverse, or exclusive-or of both.
// (RQ19) Compare result is one mask bit; destination may be the mask source.
// (RQ20) Compare tail elements are always handled as tail-agnostic.
// (RQ21) Equal and not-equal raise invalid only for signalling NaN.
// (RQ22) Ordered compares raise invalid for any NaN operand.
// (RQ23) With a NaN operand not-equal writes one, all others write zero.
// (RQ24) Greater-than exists only in vector-scalar form.
`timescale 1ns/1ps
`default_nettype none
module vfr_unit (
  input  wire logic            ref_clk,
  input  wire logic            reset,
  input  wire logic            req_valid,
  input  wire vfr_pkg::vfr_op_e op_sel,
  input  wire logic            use_scalar,
  input  wire logic [31:0]     second_vector_source,
  input  wire logic [31:0]     first_vector_source,
  input  wire logic [31:0]     scalar_fp_source,
  input  wire logic [2:0]      rounding_mode,
  input  wire logic            elem_active,
  input  wire logic            elem_tail,
  input  wire logic            dest_mask_bit,
  output logic                 result_valid,
  output logic [31:0]          vector_destination,
  output logic                 dest_write,
  output logic                 mask_bit,
  output logic                 mask_write,
  output logic                 invalid_operation_flag,
  output logic                 divide_by_zero_flag,
  output logic                 overflow_flag,
  output logic                 inexact_flag,
  output logic                 illegal_op
);
  import vfr_pkg::*;

  // ----------------------------------------------------------------------------
  // Types and helpers
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
    logic        data_wr;
    logic        mbit;
    logic        mask_wr;
    logic        nv;
    logic        dz;
    logic        of;
    logic        nx;
    logic        illegal;
  } vfr_state_s;

  localparam logic signed [9:0] OUT_EXP_TOP = 10'(2 * VFR_EXP_BIAS);
  localparam logic signed [9:0] OUT_EXP_LOW = -10'sd1;

  // Counts leading zeros of a stored fraction.
  function automatic logic [4:0] frac_lzc(input logic [22:0] f);
    logic [4:0] n;
    logic       hit;
    n   = 5'(VFR_FRAC_W);
    hit = 1'b0;
    for (int i = 22; i >= 0; i--) begin
      if (!hit && f[i]) begin
        n   = 5'(22 - i);
        hit = 1'b1;
      end
    end
    return n;
  endfunction

  // Ordered less-than on non-NaN values; minus zero orders below plus zero.
  function automatic logic tot_lt(input logic [31:0] a, input logic [31:0] b);
    if (a[31] != b[31]) begin
      return a[31];
    end
    return a[31] ? (a[30:0] > b[30:0]) : (a[30:0] < b[30:0]);
  endfunction

  vfr_state_s state_q;
  vfr_state_s state_d;

  logic [31:0] opa;
  logic [31:0] opb;
  logic        a_nan;
  logic        b_nan;
  logic        a_snan;
  logic        b_snan;
  logic        any_nan;
  logic        any_snan;

  // Operand selection and NaN classification.
  always_comb begin
    opa      = second_vector_source;
    opb      = use_scalar ? scalar_fp_source : first_vector_source;
    a_nan    = (opa[30:23] == VFR_EXP_MAX) && (opa[22:0] != 23'h0);
    b_nan    = (opb[30:23] == VFR_EXP_MAX) && (opb[22:0] != 23'h0);
    a_snan   = a_nan && !opa[22];
    b_snan   = b_nan && !opb[22];
    any_nan  = a_nan || b_nan;
    any_snan = a_snan || b_snan;
  end

  // ----------------------------------------------------------------------------
  // Reciprocal estimate
  // ----------------------------------------------------------------------------
  logic [31:0]       rec_res;
  logic              rec_nv;
  logic              rec_dz;
  logic              rec_ovf;
  logic [4:0]        rec_lz;
  logic signed [9:0] norm_in_exp;
  logic signed [9:0] norm_out_exp;
  logic [22:0]       norm_frac;
  logic [6:0]        lut_out;
  logic [23:0]       den_sig;
  logic              rec_exc;
  logic              max_finite;

  // Normalise, look up, rebuild the exponent and denormalise when needed.
  always_comb begin
    rec_lz       = frac_lzc(opa[22:0]);
    rec_res      = 32'h0000_0000;
    rec_nv       = 1'b0;
    rec_dz       = 1'b0;
    rec_ovf      = 1'b0;
    den_sig      = 24'h00_0000;
    if (opa[30:23] != 8'h00) begin
      norm_in_exp = {2'b00, opa[30:23]};                           // [RQ3]
      norm_frac   = opa[22:0];                                     // [RQ6]
    end else begin
      norm_in_exp = -$signed({5'h00, rec_lz});                     // [RQ3]
      norm_frac   = opa[22:0] << (rec_lz + 5'h01);                 // [RQ6]
    end
    norm_out_exp = OUT_EXP_TOP - 10'sd1 - norm_in_exp;             // [RQ4]
    lut_out      = VFR_RECIP_LUT[norm_frac[22:16]];                // [RQ2] [RQ7] [RQ8]
    rec_exc      = (norm_out_exp < OUT_EXP_LOW) || (norm_out_exp > OUT_EXP_TOP); // [RQ5]
    // Overflow picks max finite when rounding toward zero or away from this sign's infinity.
    max_finite   = (rounding_mode == round_toward_zero) ||
                   (opa[31] ? (rounding_mode == round_toward_plus_inf)
                            : (rounding_mode == round_toward_minus_inf)); // [RQ1]
    if (a_nan) begin
      rec_res = VFR_CANON_NAN;                                     // [RQ15]
      rec_nv  = a_snan;
    end else if (opa[30:0] == 31'h0) begin
      rec_res = {opa[31], VFR_INF_MAG};                            // [RQ15]
      rec_dz  = 1'b1;
    end else if (opa[30:23] == VFR_EXP_MAX) begin
      rec_res = {opa[31], 31'h0000_0000};                          // [RQ15]
    end else if (rec_exc) begin
      rec_ovf = 1'b1;                                              // [RQ14]
      rec_res = {opa[31], max_finite ? VFR_MAXF_MAG : VFR_INF_MAG}; // [RQ1] [RQ14]
    end else if (norm_out_exp == 10'sd0 || norm_out_exp == OUT_EXP_LOW) begin
      den_sig = {1'b1, lut_out, 16'h0000} >> (10'sd1 - norm_out_exp); // [RQ9] [RQ13]
      rec_res = {opa[31], 8'h00, den_sig[22:0]};                   // [RQ9] [RQ11]
    end else begin
      rec_res = {opa[31], norm_out_exp[7:0], lut_out, 16'h0000};   // [RQ10] [RQ11] [RQ12]
    end
  end

  // ----------------------------------------------------------------------------
  // Min/max, sign injection, compares
  // ----------------------------------------------------------------------------
  logic [31:0] mm_res;
  logic        a_lt_b;
  logic        b_lt_a;
  logic        ab_eq;
  logic        cmp_res;
  logic        cmp_nv;
  logic        is_cmp;
  logic        form_bad;

  always_comb begin
    a_lt_b = !any_nan && tot_lt(opa, opb) && !((opa[30:0] | opb[30:0]) == 31'h0);
    b_lt_a = !any_nan && tot_lt(opb, opa) && !((opa[30:0] | opb[30:0]) == 31'h0);
    ab_eq  = !any_nan && ((opa == opb) || ((opa[30:0] | opb[30:0]) == 31'h0));
    // Quiet NaNs yield the other operand; two NaNs yield the canonical NaN.
    if (a_nan && b_nan) begin
      mm_res = VFR_CANON_NAN;                                      // [RQ16]
    end else if (a_nan) begin
      mm_res = opb;
    end else if (b_nan) begin
      mm_res = opa;
    end else if ((op_sel == VFR_OP_MIN) == tot_lt(opa, opb)) begin
      mm_res = opa;                                                // [RQ16]
    end else begin
      mm_res = opb;
    end
    is_cmp   = 1'b1;
    form_bad = 1'b0;
    cmp_nv   = any_nan;                                            // [RQ22]
    case (op_sel)
      VFR_OP_CMP_EQ: begin
        cmp_res = ab_eq;                                           // [RQ23]
        cmp_nv  = any_snan;                                        // [RQ21]
      end
      VFR_OP_CMP_NE: begin
        cmp_res = !ab_eq;                                          // [RQ23]
        cmp_nv  = any_snan;                                        // [RQ21]
      end
      VFR_OP_CMP_LT: cmp_res = a_lt_b;
      VFR_OP_CMP_LE: cmp_res = a_lt_b || ab_eq;
      VFR_OP_CMP_GT: begin
        cmp_res  = b_lt_a;
        form_bad = !use_scalar;                                    // [RQ24]
      end
      VFR_OP_CMP_GE: begin
        cmp_res  = b_lt_a || ab_eq;
        form_bad = !use_scalar;
      end
      default: begin
        cmp_res = 1'b0;
        cmp_nv  = 1'b0;
        is_cmp  = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------------
  // Result selection and state register
  // ----------------------------------------------------------------------------
  logic do_work;

  // Fills the next state; only active body elements write vector data or raise exception flags.
  always_comb begin
    state_d         = '0;
    do_work         = req_valid && elem_active && !elem_tail && !form_bad;
    state_d.valid   = req_valid;
    state_d.illegal = req_valid && form_bad;                       // [RQ24]
    state_d.data    = state_q.data;
    if (req_valid && !is_cmp) begin
      state_d.data_wr = do_work;
      case (op_sel)
        VFR_OP_RECIP: begin
          state_d.data = rec_res;
          state_d.nv   = do_work && rec_nv;                        // [RQ15]
          state_d.dz   = do_work && rec_dz;
          state_d.of   = do_work && rec_ovf;                       // [RQ14]
          state_d.nx   = do_work && rec_ovf;
        end
        VFR_OP_MIN, VFR_OP_MAX: begin
          state_d.data = mm_res;
          state_d.nv   = do_work && any_snan;                      // [RQ16]
        end
        VFR_OP_SGNJ:  state_d.data = {opb[31], opa[30:0]};         // [RQ17] [RQ18]
        VFR_OP_SGNJN: state_d.data = {!opb[31], opa[30:0]};        // [RQ17] [RQ18]
        VFR_OP_SGNJX: state_d.data = {opa[31] ^ opb[31], opa[30:0]}; // [RQ17] [RQ18]
        default:      state_d.data_wr = 1'b0;
      endcase
    end else if (req_valid && !form_bad) begin
      // Tail bits are written as one; inactive bits keep the destination bit.
      state_d.mask_wr = 1'b1;                                      // [RQ19]
      if (elem_tail) begin
        state_d.mbit = 1'b1;                                       // [RQ20]
      end else if (!elem_active) begin
        state_d.mbit = dest_mask_bit;                              // [RQ19]
      end else begin
        state_d.mbit = cmp_res;                                    // [RQ23]
        state_d.nv   = cmp_nv;                                     // [RQ21] [RQ22]
      end
    end
  end

  // Registers the whole state.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign result_valid           = state_q.valid;
  assign vector_destination     = state_q.data;
  assign dest_write             = state_q.data_wr;
  assign mask_bit               = state_q.mbit;
  assign mask_write             = state_q.mask_wr;
  assign invalid_operation_flag = state_q.nv;
  assign divide_by_zero_flag    = state_q.dz;
  assign overflow_flag          = state_q.of;
  assign inexact_flag           = state_q.nx;
  assign illegal_op             = state_q.illegal;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  logic in_act;
  assign in_act = req_valid && elem_active && !elem_tail;

  // Normal inputs well inside range: table value, zero low bits, exact exponent.
  chk_recip_lut_path: assert property (in_act && op_sel == VFR_OP_RECIP && opa[30:23] != 8'h00 && // [RQ2]
      opa[30:23] < 8'hFD |=> vector_destination[15:0] == 16'h0000 &&
      vector_destination[22:16] == VFR_RECIP_LUT[$past(opa[22:16])] &&
      vector_destination[30:23] == 8'(253 - $past(opa[30:23])) && dest_write)
    else $error("reciprocal lookup path result wrong");

  chk_recip_sign_kept: assert property (in_act && op_sel == VFR_OP_RECIP && !a_nan // [RQ11]
      |=> vector_destination[31] == $past(opa[31]))
    else $error("reciprocal sign differs from input");

  chk_recip_zero_dz: assert property (in_act && op_sel == VFR_OP_RECIP && opa[30:0] == 31'h0 // [RQ15]
      |=> divide_by_zero_flag && vector_destination[30:0] == VFR_INF_MAG && !overflow_flag)
    else $error("reciprocal of zero not infinity with divide flag");

  chk_recip_ovf_mode: assert property (in_act && op_sel == VFR_OP_RECIP && opa[30:22] == 9'h000 && // [RQ14]
      opa[21:0] != 22'h0 && rounding_mode == round_toward_zero
      |=> overflow_flag && inexact_flag && vector_destination[30:0] == VFR_MAXF_MAG)
    else $error("tiny input under toward-zero not max finite");

  chk_recip_top_sub: assert property (in_act && op_sel == VFR_OP_RECIP && opa[30:23] == 8'hFE // [RQ9]
      |=> vector_destination[30:23] == 8'h00 && vector_destination[22:21] == 2'b01)
    else $error("largest exponent input not denormalised");

  chk_sgnj_body: assert property (in_act && (op_sel == VFR_OP_SGNJN) // [RQ17]
      |=> vector_destination == {!$past(opb[31]), $past(opa[30:0])})
    else $error("negating sign injection wrong");

  chk_cmp_ne_nan: assert property (in_act && op_sel == VFR_OP_CMP_NE && any_nan // [RQ23]
      |=> mask_write && mask_bit && (invalid_operation_flag == $past(any_snan)))
    else $error("not-equal with NaN wrong");

  chk_cmp_lt_qnan: assert property (in_act && op_sel == VFR_OP_CMP_LT && any_nan // [RQ22]
      |=> mask_write && !mask_bit && invalid_operation_flag)
    else $error("less-than with NaN wrong");

  chk_cmp_tail_one: assert property (req_valid && is_cmp && !form_bad && elem_tail // [RQ20]
      |=> mask_write && mask_bit && !invalid_operation_flag)
    else $error("compare tail bit not written as one");

  chk_gt_form: assert property (req_valid && op_sel == VFR_OP_CMP_GT && !use_scalar // [RQ24]
      |=> illegal_op && !mask_write ##1 !illegal_op || $past(req_valid))
    else $error("vector-vector greater-than not refused");

  chk_one_cycle: assert property (req_valid |=> result_valid ##1 (result_valid == $past(req_valid)))
    else $error("result not one cycle after request");

  cov_recip_sub_out: cover property (in_act && op_sel == VFR_OP_RECIP && opa[30:23] == 8'hFD ##1 result_valid);
  cov_recip_ovf: cover property (in_act && op_sel == VFR_OP_RECIP && rec_ovf ##1 overflow_flag);
  cov_cmp_nan: cover property (in_act && is_cmp && any_snan ##1 invalid_operation_flag);
  cov_min_nan: cover property (in_act && op_sel == VFR_OP_MIN && a_nan && !b_nan);

endmodule // vfr_unit
`default_nettype wire

// file: tb/vfr_seq_model.sv
// Sequencer model that issues one element request at a time to the FP unit.
`timescale 1ns/1ps
`default_nettype none
module vfr_seq_model (
  input  wire logic             ref_clk,
  output var logic              req_valid,
  output var vfr_pkg::vfr_op_e  op_sel,
  output var logic              use_scalar,
  output var logic [31:0]       second_vector_source,
  output var logic [31:0]       first_vector_source,
  output var logic [31:0]       scalar_fp_source,
  output var logic [2:0]        rounding_mode,
  output var logic              elem_active,
  output var logic              elem_tail,
  output var logic              dest_mask_bit
);
  import vfr_pkg::*;
  // Idle values at time zero.
  initial begin
    req_valid = 1'b0;
    op_sel = VFR_OP_RECIP;
    use_scalar = 1'b0;
    second_vector_source = 32'h0000_0000;
    first_vector_source = 32'h0000_0000;
    scalar_fp_source = 32'h0000_0000;
    rounding_mode = 3'h0;
    elem_active = 1'b0;
    elem_tail = 1'b0;
    dest_mask_bit = 1'b0;
  end
  // Drives one request for one cycle; released operands turn to their inverse so stale data never matches.
  task automatic issue(input vfr_op_e o, input logic u, input logic [31:0] a, input logic [31:0] b,
                       input logic [2:0] rm, input logic act, input logic tl, input logic dm);
    @(negedge ref_clk);
    req_valid = 1'b1;
    op_sel = o;
    use_scalar = u;
    second_vector_source = a;
    first_vector_source = u ? ~b : b;
    scalar_fp_source = u ? b : ~b;
    rounding_mode = rm;
    elem_active = act;
    elem_tail = tl;
    dest_mask_bit = dm;
    @(negedge ref_clk);
    req_valid = 1'b0;
    second_vector_source = ~a;
    first_vector_source = ~first_vector_source;
    scalar_fp_source = ~scalar_fp_source;
  endtask
endmodule // vfr_seq_model
`default_nettype wire

// file: tb/vfr_unit_test.sv
// Self-checking testbench of the vector FP unit.
`timescale 1ns/1ps
`default_nettype none
module vfr_unit_test;
  import vfr_pkg::*;
  logic        ref_clk, reset, rv, us, act, tl, dm;
  vfr_op_e     op;
  logic [31:0] a, b, s, vd;
  logic [2:0]  rm;
  logic        res_v, dw, mb, mw, nv, dz, of, nx, ill;
  int          errors = 0;
  int          n_compared = 0;
  int          cycles = 0;
  vfr_seq_model m (.ref_clk(ref_clk), .req_valid(rv), .op_sel(op), .use_scalar(us), .second_vector_source(a),
    .first_vector_source(b), .scalar_fp_source(s), .rounding_mode(rm), .elem_active(act), .elem_tail(tl),
    .dest_mask_bit(dm));
  vfr_unit dut (.ref_clk(ref_clk), .reset(reset), .req_valid(rv), .op_sel(op), .use_scalar(us),
    .second_vector_source(a), .first_vector_source(b), .scalar_fp_source(s), .rounding_mode(rm),
    .elem_active(act), .elem_tail(tl), .dest_mask_bit(dm), .result_valid(res_v), .vector_destination(vd),
    .dest_write(dw), .mask_bit(mb), .mask_write(mw), .invalid_operation_flag(nv), .divide_by_zero_flag(dz),
    .overflow_flag(of), .inexact_flag(nx), .illegal_op(ill));
  // Clock at 20 MHz.
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Cuts a hang short well beyond the roughly 130 cycles the tests need.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [3:0] flg();
    return {nv, dz, of, nx};
  endfunction
  // Issues an active data operation and checks result, write strobe and flags {nv,dz,of,nx}.
  task automatic do_op(input vfr_op_e o, input logic u, input logic [31:0] x, input logic [31:0] y,
                       input logic [2:0] r, input logic [31:0] exp, input logic [3:0] fl);
    m.issue(o, u, x, y, r, 1'b1, 1'b0, 1'b0);
    chk("result", vd, exp);
    chk("flags", {28'h000_0000, flg()}, {28'h000_0000, fl});
    chk("write", {30'h0000_0000, res_v, dw}, 32'h0000_0003);
  endtask
  task automatic t_recip();
    logic [31:0] ti [9] = '{32'h7f76_5432, 32'h0071_8abc, 32'h3f80_0000, 32'h3fc0_0000, 32'hbfc0_ffff,
                            32'h3ffe_0000, 32'h3fff_0000, 32'h0020_0000, 32'h7e80_0000};
    logic [31:0] to [9] = '{32'h0021_4000, 32'h7e90_0000, 32'h3f7f_0000, 32'h3f2a_0000, 32'hbf2a_0000,
                            32'h3f01_0000, 32'h3f00_0000, 32'h7f7f_0000, 32'h007f_8000};
    for (int i = 0; i < 9; i++) begin
      do_op(VFR_OP_RECIP, 1'b0, ti[i], 32'h0000_0000, 3'h0, to[i], 4'h0);
    end
    $display("t_recip done");
  endtask
  task automatic t_recip_exc();
    do_op(VFR_OP_RECIP, 1'b0, 32'h0000_0000, 32'h0, 3'h0, 32'h7f80_0000, 4'h4);
    do_op(VFR_OP_RECIP, 1'b0, 32'h8000_0000, 32'h0, 3'h0, 32'hff80_0000, 4'h4);
    do_op(VFR_OP_RECIP, 1'b0, 32'hff80_0000, 32'h0, 3'h0, 32'h8000_0000, 4'h0);
    do_op(VFR_OP_RECIP, 1'b0, 32'h7f80_0001, 32'h0, 3'h0, VFR_CANON_NAN, 4'h8);
    do_op(VFR_OP_RECIP, 1'b0, 32'hffc0_0000, 32'h0, 3'h0, VFR_CANON_NAN, 4'h0);
    for (int r = 0; r < 5; r++) begin
      for (int g = 0; g < 2; g++) begin
        logic [2:0] md = r[2:0];
        logic mf = (md == round_toward_zero) || (g == 1 ? md == round_toward_plus_inf : md == round_toward_minus_inf);
        do_op(VFR_OP_RECIP, 1'b0, {g[0], 31'h0000_0001}, 32'h0, md,
              {g[0], mf ? VFR_MAXF_MAG : VFR_INF_MAG}, 4'h3);
      end
    end
    $display("t_recip_exc done");
  endtask
  task automatic t_minmax_sgnj();
    do_op(VFR_OP_MIN, 1'b0, 32'h8000_0000, 32'h0000_0000, 3'h0, 32'h8000_0000, 4'h0);
    do_op(VFR_OP_MAX, 1'b0, 32'h8000_0000, 32'h0000_0000, 3'h0, 32'h0000_0000, 4'h0);
    do_op(VFR_OP_MIN, 1'b0, 32'h7fc0_0000, 32'h3f80_0000, 3'h0, 32'h3f80_0000, 4'h0);
    do_op(VFR_OP_MAX, 1'b1, 32'h4000_0000, 32'h3f80_0000, 3'h0, 32'h4000_0000, 4'h0);
    do_op(VFR_OP_MIN, 1'b1, 32'h7f80_0001, 32'h3f80_0000, 3'h0, 32'h3f80_0000, 4'h8);
    do_op(VFR_OP_MAX, 1'b0, 32'h7fc0_0000, 32'h7f80_0001, 3'h0, VFR_CANON_NAN, 4'h8);
    do_op(VFR_OP_SGNJ, 1'b0, 32'h3fc0_1234, 32'h8000_0000, 3'h0, 32'hbfc0_1234, 4'h0);
    do_op(VFR_OP_SGNJN, 1'b1, 32'h3fc0_1234, 32'h8000_0000, 3'h0, 32'h3fc0_1234, 4'h0);
    do_op(VFR_OP_SGNJX, 1'b1, 32'h3fc0_1234, 32'h8000_0000, 3'h0, 32'hbfc0_1234, 4'h0);
    do_op(VFR_OP_SGNJX, 1'b0, 32'hbfc0_1234, 32'h8000_0000, 3'h0, 32'h3fc0_1234, 4'h0);
    $display("t_minmax_sgnj done");
  endtask
  task automatic t_cmp();
    vfr_op_e ops [6] = '{VFR_OP_CMP_EQ, VFR_OP_CMP_NE, VFR_OP_CMP_LT, VFR_OP_CMP_LE, VFR_OP_CMP_GT, VFR_OP_CMP_GE};
    logic [5:0] ord = 6'h0e;
    for (int i = 0; i < 6; i++) begin
      m.issue(ops[i], 1'b1, 32'h3f80_0000, 32'h4000_0000, 3'h0, 1'b1, 1'b0, 1'b0);
      chk("cmp", {26'h000_0000, flg(), mw, mb}, {30'h0000_0000, 1'b1, ord[i]});
      m.issue(ops[i], 1'b1, 32'h7fc0_0000, 32'h3f80_0000, 3'h0, 1'b1, 1'b0, 1'b0);
      chk("cmp qnan", {29'h0000_0000, nv, mw, mb}, {29'h0000_0000, i > 1, 1'b1, i == 1});
      m.issue(ops[i], 1'b1, 32'h3f80_0000, 32'h7f80_0001, 3'h0, 1'b1, 1'b0, 1'b0);
      chk("cmp snan", {29'h0000_0000, nv, mw, mb}, {29'h0000_0000, 1'b1, 1'b1, i == 1});
    end
    m.issue(VFR_OP_CMP_GT, 1'b0, 32'h7fc0_0000, 32'h0, 3'h0, 1'b1, 1'b0, 1'b0);
    chk("gt vv", {25'h000_0000, flg(), ill, mw, dw}, 32'h0000_0004);
    m.issue(VFR_OP_CMP_GE, 1'b0, 32'h3f80_0000, 32'h3f80_0000, 3'h0, 1'b1, 1'b0, 1'b0);
    chk("ge vv", {25'h000_0000, flg(), ill, mw, dw}, 32'h0000_0004);
    m.issue(VFR_OP_CMP_NE, 1'b0, 32'h7fc0_0000, 32'h0, 3'h0, 1'b0, 1'b0, 1'b0);
    chk("inactive", {26'h000_0000, flg(), mw, mb}, 32'h0000_0002);
    m.issue(VFR_OP_CMP_EQ, 1'b0, 32'h3f80_0000, 32'h4000_0000, 3'h0, 1'b1, 1'b1, 1'b0);
    chk("tail", {26'h000_0000, flg(), mw, mb}, 32'h0000_0003);
    m.issue(VFR_OP_RECIP, 1'b0, 32'h0000_0000, 32'h0, 3'h0, 1'b0, 1'b0, 1'b0);
    chk("idle recip", {26'h000_0000, flg(), dw, res_v}, 32'h0000_0001);
    $display("t_cmp done");
  endtask
  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Main sequence.
  initial begin
    reset = 1'b1;
    repeat (12) @(negedge ref_clk);
    reset = 1'b0;
    t_recip();
    t_recip_exc();
    t_minmax_sgnj();
    t_cmp();
    conclude();
  end
endmodule // vfr_unit_test
`default_nettype wire
